// File: verilog/vtsc_pkg.sv
// Shared constants, types and preset tables for the video timing sync control block
package vtsc_pkg;
    // ==========================================
    // Register map and fields
    localparam logic [7:0] A_LC_HI = 8'h7F, A_LC_LO = 8'h80, A_CTRL = 8'h82, A_CG_CTL = 8'h83;
    localparam logic [7:0] A_CG_PH = 8'h84, A_CG_PL = 8'h85, A_HS_LO = 8'h86, A_HS_HI = 8'h87;
    localparam logic [7:0] A_VS_LO = 8'h88, A_VS_HI = 8'h89;
    localparam int B_FPF = 7, B_BCS = 6, B_SSS = 5, B_VOP = 4, B_HOP = 3, B_FIP = 2, B_VIP = 1, B_HIP = 0;
    localparam int B_SCAN = 7, B_CG_EN = 6;
    localparam logic [7:0] CTRL_RST = 8'h1F;
    localparam logic [10:0] CGMS_LINE = 11'h029;
    localparam logic [10:0] NO_FIELD = 11'h7FF;
    // ==========================================
    // Embedded code words and levels
    localparam logic [9:0] CODE_ONES = 10'h3FF, CODE_ZERO = 10'h000;
    localparam int B_EF = 8, B_EV = 7, B_EH = 6;
    localparam logic [9:0] LEVEL_LOW = 10'h000, LEVEL_MID = 10'h200;
    // ==========================================
    // Types
    typedef enum logic [2:0] {
        M_CG = 3'h0, M_1080P = 3'h1, M_1080I = 3'h2, M_720P = 3'h3, M_525I = 3'h4, M_525P = 3'h5, M_625I = 3'h6
    } vtsc_mode_e;
    typedef enum logic [3:0] {
        LT_PICTURE_LINE = 4'h0, LT_TRI_NORMAL_FULL = 4'h1, LT_TRI_BROAD_FULL = 4'h2,
        LT_TRI_NORMAL_BOTH_HALVES = 4'h3, LT_TRI_BROAD_BOTH_HALVES = 4'h4, LT_TRI_NORMAL_THEN_BROAD = 4'h5,
        LT_TRI_BROAD_THEN_NORMAL = 4'h6, LT_PICTURE_THEN_EQUALIZING = 4'h7,
        LT_BILEVEL_NORMAL_THEN_PICTURE = 4'h8, LT_BILEVEL_NORMAL_FULL = 4'h9, LT_BILEVEL_BROAD_FULL = 4'hA,
        LT_EQUALIZING_FULL = 4'hB, LT_EQUALIZING_BOTH_HALVES = 4'hC, LT_BILEVEL_BROAD_BOTH_HALVES = 4'hD,
        LT_BILEVEL_BROAD_THEN_EQUALIZING = 4'hE, LT_EQUALIZING_THEN_BILEVEL_BROAD = 4'hF
    } vtsc_ltype_e;
    typedef enum logic [3:0] {EM_IDLE = 4'h1, EM_ONES = 4'h2, EM_Z1 = 4'h4, EM_Z2 = 4'h8} vtsc_emb_e;
    typedef struct packed {vtsc_mode_e m; vtsc_ltype_e lt; logic [10:0] bp;} vtsc_bp_s;
    typedef struct packed {
        logic cgms; logic de; logic field; vtsc_ltype_e lt; logic [9:0] y; logic [9:0] cb; logic [9:0] cr;
    } vtsc_word_s;
    typedef struct packed {
        logic [7:0] ctrl; logic cg_en; logic [5:0] cg_hdr; logic [5:0] pay_hi; logic [7:0] pay_lo;
        logic [7:0] rdata; logic rvalid;
        vtsc_emb_e em; logic emb_h; logic emb_v; logic emb_f;
        logic hs_d; logic vs_d; logic fld_der; logic fld;
        logic [15:0] pix_cnt; logic [15:0] ppl; logic [15:0] hs_cnt; logic [15:0] vs_cnt; logic [10:0] ln_cnt;
        logic [15:0] hs_rb; logic [15:0] vs_rb; logic [10:0] lc_rb; logic scan_rb;
        logic [10:0] line; vtsc_ltype_e lt; logic hs_o; logic vs_o;
    } vtsc_state_s;
    // ==========================================
    // Preset breakpoint tables
    localparam int BP_N = 53;
    localparam vtsc_bp_s BP_TBL [BP_N] = '{
        '{M_1080P, LT_TRI_BROAD_FULL, 11'h006}, '{M_1080P, LT_TRI_NORMAL_FULL, 11'h02A},
        '{M_1080P, LT_PICTURE_LINE, 11'h462}, '{M_1080P, LT_TRI_NORMAL_FULL, 11'h466},
        '{M_1080I, LT_TRI_BROAD_BOTH_HALVES, 11'h006}, '{M_1080I, LT_TRI_NORMAL_BOTH_HALVES, 11'h007},
        '{M_1080I, LT_TRI_NORMAL_FULL, 11'h015}, '{M_1080I, LT_PICTURE_LINE, 11'h231},
        '{M_1080I, LT_TRI_NORMAL_FULL, 11'h233}, '{M_1080I, LT_TRI_NORMAL_THEN_BROAD, 11'h234},
        '{M_1080I, LT_TRI_BROAD_BOTH_HALVES, 11'h238}, '{M_1080I, LT_TRI_BROAD_THEN_NORMAL, 11'h239},
        '{M_1080I, LT_TRI_NORMAL_FULL, 11'h248}, '{M_1080I, LT_PICTURE_LINE, 11'h464},
        '{M_1080I, LT_TRI_NORMAL_FULL, 11'h466},
        '{M_720P, LT_TRI_BROAD_FULL, 11'h006}, '{M_720P, LT_TRI_NORMAL_FULL, 11'h01A},
        '{M_720P, LT_PICTURE_LINE, 11'h2EA}, '{M_720P, LT_TRI_NORMAL_FULL, 11'h2EF},
        '{M_525I, LT_EQUALIZING_BOTH_HALVES, 11'h004}, '{M_525I, LT_BILEVEL_BROAD_BOTH_HALVES, 11'h007},
        '{M_525I, LT_EQUALIZING_BOTH_HALVES, 11'h00A}, '{M_525I, LT_BILEVEL_NORMAL_FULL, 11'h014},
        '{M_525I, LT_PICTURE_LINE, 11'h107}, '{M_525I, LT_PICTURE_THEN_EQUALIZING, 11'h108},
        '{M_525I, LT_EQUALIZING_BOTH_HALVES, 11'h10A}, '{M_525I, LT_EQUALIZING_THEN_BILEVEL_BROAD, 11'h10B},
        '{M_525I, LT_BILEVEL_BROAD_BOTH_HALVES, 11'h10D}, '{M_525I, LT_BILEVEL_BROAD_THEN_EQUALIZING, 11'h10E},
        '{M_525I, LT_EQUALIZING_BOTH_HALVES, 11'h110}, '{M_525I, LT_EQUALIZING_FULL, 11'h111},
        '{M_525I, LT_BILEVEL_NORMAL_FULL, 11'h11A}, '{M_525I, LT_BILEVEL_NORMAL_THEN_PICTURE, 11'h11B},
        '{M_525I, LT_PICTURE_LINE, 11'h20E},
        '{M_525P, LT_BILEVEL_NORMAL_FULL, 11'h00A}, '{M_525P, LT_BILEVEL_BROAD_FULL, 11'h010},
        '{M_525P, LT_BILEVEL_NORMAL_FULL, 11'h02E}, '{M_525P, LT_PICTURE_LINE, 11'h20E},
        '{M_625I, LT_BILEVEL_BROAD_BOTH_HALVES, 11'h003}, '{M_625I, LT_BILEVEL_BROAD_THEN_EQUALIZING, 11'h004},
        '{M_625I, LT_EQUALIZING_BOTH_HALVES, 11'h006}, '{M_625I, LT_BILEVEL_NORMAL_FULL, 11'h017},
        '{M_625I, LT_BILEVEL_NORMAL_THEN_PICTURE, 11'h018}, '{M_625I, LT_PICTURE_LINE, 11'h137},
        '{M_625I, LT_EQUALIZING_BOTH_HALVES, 11'h139}, '{M_625I, LT_EQUALIZING_THEN_BILEVEL_BROAD, 11'h13A},
        '{M_625I, LT_BILEVEL_BROAD_BOTH_HALVES, 11'h13C}, '{M_625I, LT_EQUALIZING_BOTH_HALVES, 11'h13E},
        '{M_625I, LT_EQUALIZING_FULL, 11'h13F}, '{M_625I, LT_BILEVEL_NORMAL_FULL, 11'h150},
        '{M_625I, LT_PICTURE_LINE, 11'h26F}, '{M_625I, LT_PICTURE_THEN_EQUALIZING, 11'h270},
        '{M_625I, LT_EQUALIZING_BOTH_HALVES, 11'h272}
    };
    // ==========================================
    // Preset sizes and lookup
    function automatic logic [10:0] frame_size(input vtsc_mode_e m);
        case (m)
            M_1080P, M_1080I: return 11'h465;
            M_720P: return 11'h2EE;
            M_525I, M_525P: return 11'h20D;
            M_625I: return 11'h271;
            default: return NO_FIELD;
        endcase
    endfunction
    function automatic logic [10:0] field_size(input vtsc_mode_e m);
        case (m)
            M_1080I: return 11'h233;
            M_525I: return 11'h107;
            M_625I: return 11'h138;
            default: return NO_FIELD;
        endcase
    endfunction
    function automatic logic is_sd(input vtsc_mode_e m);
        return (m == M_525I) || (m == M_525P) || (m == M_625I);
    endfunction
    function automatic vtsc_ltype_e lt_lookup(input vtsc_mode_e m, input logic [10:0] ln);
        vtsc_ltype_e cur;
        vtsc_ltype_e wrap;
        logic hit;
        cur = LT_PICTURE_LINE;
        wrap = LT_PICTURE_LINE;
        hit = 1'h0;
        for (int i = 0; i < BP_N; i++) begin
            if (BP_TBL[i].m == m) begin
                wrap = BP_TBL[i].lt;
                if (BP_TBL[i].bp <= ln) begin
                    cur = BP_TBL[i].lt;
                    hit = 1'h1;
                end
            end
        end
        return hit ? cur : wrap;
    endfunction
endpackage

// File: verilog/vtsc_top.sv
// Video timing sync control: sync decode, measurement, presets, blanking and copy-info path
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Output FIFO
module vtsc_fifo #(
    parameter int W = 37,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = AW + 1;
    typedef struct packed {
        logic [D-1:0][W-1:0] mem; logic [AW-1:0] wp; logic [AW-1:0] rp; logic [CW-1:0] cnt;
        logic irdy; logic ov; logic [W-1:0] od;
    } vtsc_fifo_s;
    localparam vtsc_fifo_s F_RST = '{irdy: 1'h1, default: '0};

    vtsc_fifo_s f_r;
    vtsc_fifo_s f_nxt;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : AW'(p + 1'h1);
    endfunction

    always_comb begin
        f_nxt = f_r;
        push = in_valid && f_r.irdy;
        pop = (f_r.cnt != '0) && (!f_r.ov || out_ready);
        if (push) begin
            f_nxt.mem[f_r.wp] = in_data;
            f_nxt.wp = ptr_inc(f_r.wp);
        end
        if (pop) begin
            f_nxt.od = f_r.mem[f_r.rp];
            f_nxt.rp = ptr_inc(f_r.rp);
            f_nxt.ov = 1'h1;
        end else if (out_ready) begin
            f_nxt.ov = 1'h0;
        end
        f_nxt.cnt = f_r.cnt + CW'(push) - CW'(pop);
        f_nxt.irdy = f_nxt.cnt < CW'(D);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            f_r <= F_RST;
        end else if (clk_en) begin
            f_r <= f_nxt;
        end
    end

    assign in_ready = f_r.irdy;
    assign out_valid = f_r.ov;
    assign out_data = f_r.od;
endmodule

// ==========================================
// Top level
module vtsc_top
    import vtsc_pkg::*;
#(
    parameter logic [9:0] BLANK_OFFSET = 10'h000,
    parameter int FIFO_DEPTH = 8
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // Host register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Timing generator preset
    input wire logic [2:0] tg_mode,
    // Video input
    input wire logic hsync_input,
    input wire logic vsync_input,
    input wire logic field_pin,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [29:0] pix_data,
    // Video output
    output logic out_valid,
    input wire logic out_ready,
    output logic [$bits(vtsc_word_s)-1:0] out_word,
    output logic hsync_output,
    output logic vsync_output,
    output logic [3:0] line_type,
    output logic field_id,
    output logic [19:0] cgms_word
);
    localparam vtsc_state_s ST_RST = '{ctrl: CTRL_RST, em: EM_IDLE, lt: LT_PICTURE_LINE, default: '0};

    vtsc_state_s st_r;
    vtsc_state_s st_nxt;
    vtsc_mode_e mode;
    vtsc_word_s wd;
    vtsc_ltype_e lt_now;
    logic [9:0] y_in;
    logic hs_a, vs_a, fid_a, hs_lv, vs_lv, hs_rise, vs_rise, fs, fld, fld_der, de_mode, de_lv, sss;

    // ==========================================
    // Sync decode
    always_comb begin
        mode = vtsc_mode_e'(tg_mode);
        y_in = pix_data[29:20];
        sss = st_r.ctrl[B_SSS];
        hs_a = hsync_input ~^ st_r.ctrl[B_HIP];
        vs_a = vsync_input ~^ st_r.ctrl[B_VIP];
        fid_a = field_pin ~^ st_r.ctrl[B_FIP];
        hs_lv = sss ? st_r.emb_h : hs_a;
        vs_lv = sss ? st_r.emb_v : vs_a;
        hs_rise = hs_lv && !st_r.hs_d;
        vs_rise = vs_lv && !st_r.vs_d;
        fld_der = vs_rise ? (st_r.pix_cnt > {1'h0, st_r.ppl[15:1]}) : st_r.fld_der;
        if (sss) begin
            fld = st_r.emb_f;
        end else if (st_r.ctrl[B_FPF] && mode != M_CG) begin
            fld = fld_der;
        end else if (st_r.ctrl[B_FPF]) begin
            fld = 1'h0;
        end else begin
            fld = fid_a;
        end
        fs = vs_rise && !fld;
        de_mode = st_r.ctrl[B_FPF] && (mode == M_CG);
        de_lv = fid_a;
        lt_now = lt_lookup(mode, st_r.line);
    end

    // ==========================================
    // Pixel word into the FIFO
    always_comb begin
        wd.cgms = st_r.cg_en && is_sd(mode) && (st_r.line == CGMS_LINE);
        wd.de = de_mode ? de_lv : 1'h1;
        wd.field = fld;
        wd.lt = st_r.lt;
        if (de_mode && !de_lv) begin
            wd.y = LEVEL_LOW + BLANK_OFFSET;
            wd.cb = st_r.ctrl[B_BCS] ? LEVEL_LOW + BLANK_OFFSET : LEVEL_MID;
            wd.cr = st_r.ctrl[B_BCS] ? LEVEL_LOW + BLANK_OFFSET : LEVEL_MID;
        end else begin
            {wd.y, wd.cb, wd.cr} = pix_data;
        end
    end

    // ==========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Embedded code detection
        if (pix_valid && pix_ready) begin
            case (st_r.em)
                EM_IDLE: st_nxt.em = (y_in == CODE_ONES) ? EM_ONES : EM_IDLE;
                EM_ONES: st_nxt.em = (y_in == CODE_ZERO) ? EM_Z1 : ((y_in == CODE_ONES) ? EM_ONES : EM_IDLE);
                EM_Z1: st_nxt.em = (y_in == CODE_ZERO) ? EM_Z2 : EM_IDLE;
                EM_Z2: begin
                    st_nxt.em = EM_IDLE;
                    st_nxt.emb_h = y_in[B_EH];
                    st_nxt.emb_v = y_in[B_EV];
                    st_nxt.emb_f = y_in[B_EF];
                end
                default: st_nxt.em = EM_IDLE;
            endcase
        end
        // Measurements
        st_nxt.hs_d = hs_lv;
        st_nxt.vs_d = vs_lv;
        st_nxt.fld_der = fld_der;
        st_nxt.fld = fld;
        st_nxt.pix_cnt = hs_rise ? 16'h0001 : 16'(st_r.pix_cnt + 16'h0001);
        st_nxt.ppl = hs_rise ? st_r.pix_cnt : st_r.ppl;
        if (fs) begin
            st_nxt.hs_rb = st_r.hs_cnt;
            st_nxt.vs_rb = st_r.vs_cnt;
            st_nxt.lc_rb = st_r.ln_cnt;
            st_nxt.scan_rb = (mode == M_CG) ? st_r.ln_cnt[0] : (field_size(mode) != NO_FIELD);
            st_nxt.hs_cnt = {15'h0000, hs_lv};
            st_nxt.vs_cnt = {15'h0000, hs_rise && vs_lv};
            st_nxt.ln_cnt = {10'h000, hs_rise};
            st_nxt.line = 11'h001;
        end else begin
            st_nxt.hs_cnt = 16'(st_r.hs_cnt + {15'h0000, hs_lv});
            st_nxt.vs_cnt = 16'(st_r.vs_cnt + {15'h0000, hs_rise && vs_lv});
            st_nxt.ln_cnt = 11'(st_r.ln_cnt + {10'h000, hs_rise});
            if (hs_rise) begin
                st_nxt.line = (st_r.line >= frame_size(mode)) ? 11'h001 : 11'(st_r.line + 11'h001);
            end
        end
        st_nxt.lt = lt_now;
        st_nxt.hs_o = hs_lv ~^ st_r.ctrl[B_HOP];
        st_nxt.vs_o = vs_lv ~^ st_r.ctrl[B_VOP];
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: st_nxt.ctrl = reg_wdata;
                A_CG_CTL: begin
                    st_nxt.cg_en = reg_wdata[B_CG_EN];
                    st_nxt.cg_hdr = reg_wdata[5:0];
                end
                A_CG_PH: st_nxt.pay_hi = reg_wdata[5:0];
                A_CG_PL: st_nxt.pay_lo = reg_wdata;
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end
        // Register reads
        st_nxt.rvalid = reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                A_LC_HI: st_nxt.rdata = {st_r.scan_rb, 4'h0, st_r.lc_rb[10:8]};
                A_LC_LO: st_nxt.rdata = st_r.lc_rb[7:0];
                A_CTRL: st_nxt.rdata = st_r.ctrl;
                A_CG_CTL: st_nxt.rdata = {1'h0, st_r.cg_en, st_r.cg_hdr};
                A_CG_PH: st_nxt.rdata = {2'h0, st_r.pay_hi};
                A_CG_PL: st_nxt.rdata = st_r.pay_lo;
                A_HS_LO: st_nxt.rdata = st_r.hs_rb[7:0];
                A_HS_HI: st_nxt.rdata = st_r.hs_rb[15:8];
                A_VS_LO: st_nxt.rdata = st_r.vs_rb[7:0];
                A_VS_HI: st_nxt.rdata = st_r.vs_rb[15:8];
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= ST_RST;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Output FIFO and outputs
    vtsc_fifo #(
        .W($bits(vtsc_word_s)),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(wd),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_word)
    );

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign hsync_output = st_r.hs_o;
    assign vsync_output = st_r.vs_o;
    assign line_type = st_r.lt;
    assign field_id = st_r.fld;
    assign cgms_word = {st_r.cg_hdr, st_r.pay_hi, st_r.pay_lo};

    // ==========================================
    // Assertions
    default clocking cb_main @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_scan_rd;
        clk_en && reg_rd && reg_addr == A_LC_HI |=> reg_rvalid && reg_rdata[B_SCAN] == $past(st_r.scan_rb);
    endproperty
    a_scan_rd: assert property (p_scan_rd) else $error("scan flag readback wrong");
    property p_lc_cap;
        clk_en && fs |=> st_r.lc_rb == $past(st_r.ln_cnt) && st_r.ln_cnt <= 11'h001;
    endproperty
    a_lc_cap: assert property (p_lc_cap) else $error("line count not captured");
    property p_fid_pin;
        clk_en && !sss && !st_r.ctrl[B_FPF] |=> field_id == $past(fid_a);
    endproperty
    a_fid_pin: assert property (p_fid_pin) else $error("field id not from pin");
    property p_blank;
        clk_en && de_mode && !de_lv |-> wd.y == BLANK_OFFSET && !wd.de;
    endproperty
    a_blank: assert property (p_blank) else $error("blanking not substituted");
    property p_ctrl_rst;
        disable iff (1'h0) reset |=> st_r.ctrl == CTRL_RST;
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst) else $error("control reset value wrong");
    property p_hsync_output;
        clk_en |=> hsync_output == ($past(hs_lv) ~^ $past(st_r.ctrl[B_HOP]));
    endproperty
    a_hsync_output: assert property (p_hsync_output) else $error("hsync output polarity wrong");
    property p_hs_hi;
        clk_en && fs |=> st_r.hs_rb == $past(st_r.hs_cnt);
    endproperty
    a_hs_hi: assert property (p_hs_hi) else $error("hsync high count not captured");
    property p_vs_hi;
        clk_en && fs |=> st_r.vs_rb == $past(st_r.vs_cnt);
    endproperty
    a_vs_hi: assert property (p_vs_hi) else $error("vsync high count not captured");
    property p_cgms;
        clk_en && (st_r.line != CGMS_LINE || !st_r.cg_en) |-> !wd.cgms;
    endproperty
    a_cgms: assert property (p_cgms) else $error("copy info on wrong line");
    property p_lt;
        clk_en |=> line_type == $past(lt_now);
    endproperty
    a_lt: assert property (p_lt) else $error("line type not from table");

    c_frame: cover property (clk_en && fs);
    c_cgms: cover property (clk_en && wd.cgms && pix_valid);
    c_full: cover property (!pix_ready ##1 pix_ready);
    c_blank: cover property (clk_en && de_mode && !de_lv && pix_valid);
endmodule

`default_nettype wire

// File: tb/vtsc_src.sv
// Video source model: line and frame sync pulses
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Sync source
module vtsc_src (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Syncs and raster position
    output logic hs,
    output logic vs,
    output logic [4:0] ln,
    output logic [4:0] pos
);
    always_ff @(posedge mclk) begin
        if (reset) begin
            pos <= 5'h00;
            ln <= 5'h00;
        end else begin
            pos <= (pos == 5'h13) ? 5'h00 : pos + 5'h01;
            if (pos == 5'h13)
                ln <= (ln == 5'h09) ? 5'h00 : ln + 5'h01;
        end
    end
    // Twenty clocks a line, ten lines a frame, vsync two lines from mid-line
    assign hs = !reset && pos < 5'h04;
    assign vs = !reset && ((ln == 5'h00 && pos >= 5'h0A) || ln == 5'h01 || (ln == 5'h02 && pos < 5'h0A));
endmodule
`default_nettype wire

// File: tb/tb.sv
// Testbench: registers, measurement, presets and data path
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk, reset, reg_wr, reg_rd, field_pin, pix_valid, pix_ready, out_ready, out_valid, reg_rvalid;
    logic hs, vs, hso, vso, fid, clk_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] tg_mode;
    logic [29:0] pix_data;
    logic [36:0] out_word;
    logic [3:0] line_type;
    logic [19:0] cgms_word;
    logic [4:0] ln, pos;
    int errors = 0, checks = 0, cyc = 0, n;
    logic [11:0] lt_tbl [13] = '{12'h162, 12'h151, 12'h273, 12'h264, 12'h362, 12'h351, 12'h47D,
        12'h44C, 12'h5A9, 12'h590, 12'h64E, 12'h63D, 12'h060};
    vtsc_src SRC (.mclk(mclk), .reset(reset), .hs(hs), .vs(vs), .ln(ln), .pos(pos));
    vtsc_top DUT (.mclk(mclk), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .tg_mode(tg_mode), .hsync_input(hs), .vsync_input(vs), .field_pin(field_pin), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_word(out_word), .hsync_output(hso), .vsync_output(vso), .line_type(line_type), .field_id(fid),
        .cgms_word(cgms_word));
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        chk(32'({reg_rvalid, reg_rdata}), 32'({1'h1, exp}));
    endtask
    task automatic at(input logic [4:0] l, p);
        int i;
        i = 0;
        do begin
            @(posedge mclk);
            #1;
            i++;
        end while (!(ln === l && pos === p) && i < 400);
    endtask
    task automatic px(input logic [29:0] v, exp);
        @(posedge mclk);
        pix_valid <= 1'h1;
        pix_data <= v;
        @(posedge mclk);
        pix_valid <= 1'h0;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (out_valid !== 1'h1 && n < 20);
        chk(32'(out_word[29:0]), 32'(exp));
    endtask
    task automatic report_and_stop;
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // Clock, timeout, tests
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        reset = 1'h1;
        clk_en = 1'h1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        tg_mode = 3'h0;
        field_pin = 1'h0;
        pix_valid = 1'h0;
        pix_data = 30'h0;
        out_ready = 1'h1;
        repeat (8) @(posedge mclk);
        reset <= 1'h0;
        rd(8'h82, 8'h1F);
        rd(8'h83, 8'h00);
        rd(8'h85, 8'h00);
        rd(8'h81, 8'h00);
        wr(8'h83, 8'h45);
        wr(8'h84, 8'hFF);
        wr(8'h85, 8'hA5);
        wr(8'h86, 8'hFF);
        rd(8'h83, 8'h45);
        rd(8'h84, 8'h3F);
        chk(32'(cgms_word), 32'h17FA5);
        foreach (lt_tbl[i]) begin
            @(posedge mclk);
            tg_mode <= lt_tbl[i][10:8];
            at(5'(lt_tbl[i][7:4]) - 5'h01, 5'h0C);
            chk(32'(line_type), 32'(lt_tbl[i][3:0]));
        end
        @(posedge mclk);
        tg_mode <= 3'h2;
        at(5'h03, 5'h00);
        at(5'h03, 5'h00);
        rd(8'h7F, 8'h80);
        rd(8'h80, 8'h0A);
        rd(8'h86, 8'h28);
        rd(8'h87, 8'h00);
        rd(8'h88, 8'h02);
        rd(8'h89, 8'h00);
        @(posedge mclk);
        tg_mode <= 3'h1;
        at(5'h03, 5'h00);
        at(5'h03, 5'h00);
        rd(8'h7F, 8'h00);
        wr(8'h82, 8'h07);
        at(5'h04, 5'h02);
        chk(32'(hso), 32'h0);
        chk(32'(vso), 32'h1);
        wr(8'h82, 8'h1F);
        at(5'h04, 5'h02);
        chk(32'(hso), 32'h1);
        chk(32'(vso), 32'h0);
        @(posedge mclk);
        tg_mode <= 3'h4;
        at(5'h01, 5'h0C);
        @(posedge mclk);
        field_pin <= 1'h1;
        repeat (4) at(5'h00, 5'h05);
        px(30'h1234567, 30'h1234567);
        chk(32'(out_word[36]), 32'h1);
        chk(32'(fid), 32'h1);
        wr(8'h82, 8'h9F);
        at(5'h02, 5'h00);
        chk(32'(fid), 32'h0);
        @(posedge mclk);
        tg_mode <= 3'h0;
        field_pin <= 1'h1;
        wr(8'h82, 8'h9F);
        px(30'h2345678, 30'h2345678);
        chk(32'(out_word[36]), 32'h0);
        @(posedge mclk);
        field_pin <= 1'h0;
        px(30'h2345678, 30'h0080200);
        chk(32'(out_word[35]), 32'h0);
        wr(8'h82, 8'hDF);
        px(30'h2345678, 30'h0000000);
        wr(8'h82, 8'h3F);
        for (int k = 0; k < 2; k++) begin
            px(30'h3FF00000, 30'h3FF00000);
            px(30'h0, 30'h0);
            px(30'h0, 30'h0);
            px(k ? 30'h0 : 30'h04000000, k ? 30'h0 : 30'h04000000);
            chk(32'(hso), 32'(k == 0));
        end
        @(posedge mclk);
        clk_en <= 1'h0;
        wr(8'h83, 8'h00);
        clk_en <= 1'h1;
        rd(8'h83, 8'h45);
        @(posedge mclk);
        out_ready <= 1'h0;
        pix_valid <= 1'h1;
        n = 0;
        repeat (20) begin
            #1;
            if (pix_ready === 1'h1) n++;
            @(posedge mclk);
        end
        chk(32'(n), 32'h9);
        pix_valid <= 1'h0;
        out_ready <= 1'h1;
        n = 0;
        repeat (20) begin
            #1;
            if (out_valid === 1'h1) n++;
            @(posedge mclk);
        end
        chk(32'(n), 32'h9);
        report_and_stop();
    end
endmodule
`default_nettype wire
